// >>> hbf_fault_mgr.sv
/*
  hbf_fault_mgr: fault handling for a six-channel half-bridge driver.
  Assumes a frame decoder delivers frameValid pulses with decoded control bits,
  and that analog detectors deliver asynchronous fault levels (synchronised here).
*/
`default_nettype none
module hbf_fault_mgr
  import hbf_pkg::*;
#(
  parameter int NB = hbf_pkg::NUM_BRIDGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enablePin,
  input wire logic frameValid,
  input wire logic statusResetRequest,
  input wire logic underloadShutdownCtrl,
  input wire logic overvoltageLockoutEn,
  input wire logic [NB-1:0] newEnable,
  input wire logic [2*NB-1:0] newConfig,
  input wire logic [NB-1:0] overcurrentDet,
  input wire logic [NB-1:0] underloadDet,
  input wire logic [NB-1:0] thermalWarnDet,
  input wire logic [NB-1:0] thermalShutDet,
  input wire logic overvoltageDet,
  input wire logic undervoltageDet,
  output logic [NB-1:0] halfBridgeEnable,
  output logic [2*NB-1:0] halfBridgeConfig,
  output logic [NB-1:0] driveAllowed,
  output logic [NB-1:0] latchedOff,
  output logic overcurrentFlag,
  output logic underloadFlag,
  output logic thermalWarningFlag,
  output logic thermalShutdownFlag,
  output logic supplyFailFlag,
  output logic [15:0] faultFrame
);
  localparam int SW = 4 * NB + 3;

  // whole state in one packed word
  typedef struct packed {
    logic [NB-1:0] en;
    logic [2*NB-1:0] cfg;
    logic [NB-1:0] latch;
    logic ocFlag;
    logic ulFlag;
    logic tsd;
    logic enPrev;
    logic ulShut;
    logic ovLock;
  } hbf_state_t;

  hbf_state_t st_ff;
  hbf_state_t nxt_st;
  logic [SW-1:0] syncOut;
  logic [NB-1:0] sOc, sUl, sWarn, sTs;
  logic sOv, sUv, sEn, clearReq, supplyLock;

  // all pins leave the analog domain through two flops
  hbf_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({enablePin, overvoltageDet, undervoltageDet, thermalShutDet, thermalWarnDet, underloadDet,
          overcurrentDet}),
    .dout(syncOut)
  );
  // slices of the synchronised bus, one group per fault class
  assign sOc = syncOut[NB-1:0];
  assign sUl = syncOut[2*NB-1:NB];
  assign sWarn = syncOut[3*NB-1:2*NB];
  assign sTs = syncOut[4*NB-1:3*NB];
  assign sUv = syncOut[4*NB];
  assign sOv = syncOut[4*NB+1];
  assign sEn = syncOut[4*NB+2];

  // a status reset frame or an enable low level clears latched state
  assign clearReq = (frameValid && statusResetRequest) || !sEn;
  // supply lockout is global and keeps configuration intact
  assign supplyLock = sUv || (sOv && st_ff.ovLock);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.enPrev = sEn;
    // control bits are captured on every frame, even with enable low
    if (frameValid) begin
      nxt_st.ulShut = underloadShutdownCtrl;
      nxt_st.ovLock = overvoltageLockoutEn;
    end
    // clear first so that a new fault in the same cycle wins
    if (clearReq) begin
      nxt_st.ocFlag = 1'b0;
      nxt_st.ulFlag = 1'b0;
      nxt_st.latch = '0;
      nxt_st.tsd = 1'b0;
    end
    // frames only program bridges while the enable pin is high
    if (frameValid && sEn) begin
      nxt_st.en = newEnable;
      nxt_st.cfg = newConfig;
    end
    // enable low wipes the bridge enables and configuration, which is the pin cycle clear
    if (!sEn) begin
      nxt_st.en = '0;
      nxt_st.cfg = '0;
    end
    for (int i = 0; i < NB; i++) begin
      // thermal shutdown stays latched while still hot, even across a clear
      if (sOc[i] || sTs[i] || (sUl[i] && st_ff.ulShut)) begin
        nxt_st.latch[i] = 1'b1;
        nxt_st.en[i] = 1'b0;
        nxt_st.cfg[2*i +: 2] = RST_CFG;
      end
    end
    if (|sOc) nxt_st.ocFlag = 1'b1;
    if (|sUl) nxt_st.ulFlag = 1'b1;
    if (|sTs) nxt_st.tsd = 1'b1;
  end

  // state register, lockout enabled out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{en: '0, cfg: '0, latch: '0, ocFlag: 1'b0, ulFlag: 1'b0, tsd: 1'b0,
                 enPrev: 1'b0, ulShut: RST_UL_SHUT, ovLock: RST_OV_LOCK};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // drivers run only when enabled, not latched and not locked out
  assign driveAllowed = supplyLock ? '0 : (st_ff.en & ~st_ff.latch);
  assign halfBridgeEnable = st_ff.en;
  assign halfBridgeConfig = st_ff.cfg;
  assign latchedOff = st_ff.latch;
  assign overcurrentFlag = st_ff.ocFlag;
  assign underloadFlag = st_ff.ulFlag;
  assign thermalShutdownFlag = st_ff.tsd;
  assign thermalWarningFlag = |sWarn;
  assign supplyFailFlag = sOv || sUv;

  // output frame image built from the flags
  always_comb begin
    faultFrame = 16'h0000;
    faultFrame[BIT_WARN] = thermalWarningFlag;
    faultFrame[BIT_UNDERLOAD] = underloadFlag;
    faultFrame[BIT_SUPPLY_FAIL] = supplyFailFlag;
    faultFrame[BIT_OVERCURRENT] = overcurrentFlag;
  end

  // checks run on the design clock and pause during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // latched classes: the bridge goes off and stays off until a clear
  chk_oc_latch: assert property (sOc[0] |=> latchedOff[0] && !halfBridgeEnable[0])
    else $error("overcurrent did not latch bridge 0 off");
  chk_latch_hold: assert property (latchedOff[0] && !clearReq |=> latchedOff[0])
    else $error("latched bridge 0 released without clear");
  chk_latch_cfg_zero: assert property ($rose(latchedOff[1]) |-> halfBridgeConfig[3:2] == 2'h0)
    else $error("latched bridge config not cleared");
  chk_ts_latch: assert property (sTs[2] |=> latchedOff[2])
    else $error("hot bridge 2 not held latched off");

  // under-load only shuts the bridge down when the control bit asks for it
  chk_ul_noshut: assert property (sUl[1] && !st_ff.ulShut && !sOc[1] && !sTs[1] && !latchedOff[1]
      |=> !latchedOff[1])
    else $error("underload latched bridge with shutdown disabled");
  chk_ul_shut: assert property (sUl[1] && st_ff.ulShut |=> latchedOff[1])
    else $error("underload did not latch with shutdown enabled");

  // flags: latched ones hold until a clear, the warning never shuts down
  chk_flag_hold: assert property (overcurrentFlag && !clearReq |=> overcurrentFlag)
    else $error("overcurrent flag dropped without clear");
  chk_clear_req: assert property (clearReq && !(|sOc) |=> !overcurrentFlag)
    else $error("overcurrent flag survived clear");
  chk_warn_nolatch: assert property (sWarn[2] && !sOc[2] && !sTs[2] && !sUl[2] && !latchedOff[2]
      |=> !latchedOff[2])
    else $error("thermal warning latched a bridge off");

  // supply faults: global lockout that keeps every setting
  chk_supply_lock: assert property (sUv |-> driveAllowed == '0)
    else $error("drivers active during undervoltage");
  chk_ov_keep: assert property (sOv && st_ff.ovLock && sEn && !frameValid && !(|sOc) && !(|sTs)
      && !(|sUl) |=> $stable(halfBridgeEnable))
    else $error("overvoltage lockout altered configuration");
  chk_uv_keep: assert property (sUv && sEn && !frameValid && !(|sOc) && !(|sTs) && !(|sUl)
      |=> $stable(halfBridgeConfig))
    else $error("undervoltage lockout altered configuration");
  chk_ov_nolock: assert property (sOv && !sUv && !st_ff.ovLock && halfBridgeEnable[4] && !latchedOff[4]
      |-> driveAllowed[4])
    else $error("overvoltage stopped bridge 4 with lockout disabled");
  chk_supply_bit: assert property (faultFrame[BIT_SUPPLY_FAIL] == (sOv || sUv))
    else $error("supply fail bit mismatch");

  // enable pin low wipes settings, so a pin cycle needs a fresh frame
  chk_pin_clear: assert property (!sEn |=> halfBridgeEnable == '0 && halfBridgeConfig == '0)
    else $error("settings survived enable pin low");
  chk_other_bridge: assert property (sOc[0] && !sOc[1] && !sTs[1] && !sUl[1] && !frameValid && sEn
      |=> $stable(halfBridgeEnable[1]))
    else $error("fault on bridge 0 altered bridge 1");

  // main scenarios
  cov_oc_event: cover property (sOc[0] ##1 latchedOff[0] ##[1:20] !latchedOff[0]);
  cov_ov_lock: cover property (sOv && st_ff.ovLock && |st_ff.en);
  cov_uv_lock: cover property (sUv ##[1:10] !sUv);
  cov_ul_flag: cover property ($rose(underloadFlag));
  cov_en_cycle: cover property (st_ff.enPrev && !sEn ##[1:20] sEn);
endmodule // hbf_fault_mgr
`default_nettype wire

// >>> hbf_pkg.sv
/*
  hbf_pkg: shared constants and types for the half-bridge fault manager.
  Assumes a single 50 MHz clock domain and synchronous active-high reset.
*/
`default_nettype none
package hbf_pkg;
  localparam int NUM_BRIDGES = 6;
  localparam int CFG_W = 2;
  // serial output frame fault bit positions
  localparam int BIT_WARN = 0;
  localparam int BIT_UNDERLOAD = 13;
  localparam int BIT_SUPPLY_FAIL = 14;
  localparam int BIT_OVERCURRENT = 15;
  // serial input control bit positions
  localparam int BIT_OV_LOCK = 0;
  localparam int BIT_UL_SHUT = 13;
  localparam logic RST_EN = 1'b0;
  localparam logic [1:0] RST_CFG = 2'h0;
  localparam logic RST_OV_LOCK = 1'b1;
  localparam logic RST_UL_SHUT = 1'b0;
  // per-bridge drive state
  typedef enum logic [1:0] {
    HBF_RUN = 2'b00,
    HBF_LOCK = 2'b01,
    HBF_LATCH = 2'b11
  } hbf_drv_t;
endpackage : hbf_pkg
`default_nettype wire

// >>> hbf_sync.sv
/*
  hbf_sync: two flip-flop synchroniser for a bus of asynchronous levels.
  Assumes inputs are quasi-static compared to the clock.
*/
`default_nettype none
module hbf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } hbf_sync_st_t;
  hbf_sync_st_t st_ff;
  hbf_sync_st_t nxt_st;

  // first stage only feeds the second stage
  always_comb begin
    nxt_st.meta = din;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.sync;
endmodule // hbf_sync
`default_nettype wire

// >>> hbf_host_model.sv
/*
  hbf_host_model: host side that issues decoded control frames to the fault manager.
  Assumes the bench calls send and that the clock is the design clock.
*/
`default_nettype none
module hbf_host_model (
  input wire logic clk,
  output logic frameValid,
  output logic statusResetRequest,
  output logic underloadShutdownCtrl,
  output logic overvoltageLockoutEn,
  output logic [5:0] newEnable,
  output logic [11:0] newConfig
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle low until the first frame; only frameValid qualifies the rest
  initial begin
    {frameValid, statusResetRequest, underloadShutdownCtrl} = 3'h0;
    {overvoltageLockoutEn, newEnable, newConfig} = 19'h0;
  end
  // one frame for one cycle, bits scrambled afterwards
  task automatic send(input logic s, input logic u, input logic o, input logic [5:0] e, input logic [11:0] c);
    @(negedge clk);
    {frameValid, statusResetRequest, underloadShutdownCtrl, overvoltageLockoutEn} = {1'b1, s, u, o};
    {newEnable, newConfig} = {e, c};
    @(negedge clk);
    {frameValid, statusResetRequest, underloadShutdownCtrl, overvoltageLockoutEn} = {1'b0, ~s, ~u, ~o};
    {newEnable, newConfig} = ~{e, c};
  endtask
endmodule // hbf_host_model
`default_nettype wire

// >>> tb_hbf_fault_mgr.sv
/*
  tb_hbf_fault_mgr: self-checking bench for the fault manager with a host model.
  Assumes fault inputs reach outputs within three clock edges.
*/
`default_nettype none
module tb_hbf_fault_mgr;
  timeunit 1ns;
  timeprecision 1ns;
  import hbf_pkg::*;
  localparam logic [11:0] CF = 12'he4b;
  localparam logic [5:0] EN = 6'h3f;
  logic clk, rst, enablePin, frameValid, statusResetRequest, underloadShutdownCtrl, overvoltageLockoutEn;
  logic overvoltageDet, undervoltageDet, overcurrentFlag, underloadFlag, thermalWarningFlag;
  logic thermalShutdownFlag, supplyFailFlag;
  logic [5:0] newEnable, overcurrentDet, underloadDet, thermalWarnDet, thermalShutDet;
  logic [5:0] halfBridgeEnable, driveAllowed, latchedOff;
  logic [11:0] newConfig, halfBridgeConfig;
  logic [15:0] faultFrame;
  int n_fail = 0;
  int cmp_count = 0;
  hbf_fault_mgr dut_u (
    .clk(clk), .rst(rst), .enablePin(enablePin), .frameValid(frameValid),
    .statusResetRequest(statusResetRequest), .underloadShutdownCtrl(underloadShutdownCtrl),
    .overvoltageLockoutEn(overvoltageLockoutEn), .newEnable(newEnable), .newConfig(newConfig),
    .overcurrentDet(overcurrentDet), .underloadDet(underloadDet), .thermalWarnDet(thermalWarnDet),
    .thermalShutDet(thermalShutDet), .overvoltageDet(overvoltageDet), .undervoltageDet(undervoltageDet),
    .halfBridgeEnable(halfBridgeEnable), .halfBridgeConfig(halfBridgeConfig),
    .driveAllowed(driveAllowed), .latchedOff(latchedOff), .overcurrentFlag(overcurrentFlag),
    .underloadFlag(underloadFlag), .thermalWarningFlag(thermalWarningFlag),
    .thermalShutdownFlag(thermalShutdownFlag), .supplyFailFlag(supplyFailFlag), .faultFrame(faultFrame)
  );
  hbf_host_model host_u (
    .clk(clk), .frameValid(frameValid), .statusResetRequest(statusResetRequest),
    .underloadShutdownCtrl(underloadShutdownCtrl), .overvoltageLockoutEn(overvoltageLockoutEn),
    .newEnable(newEnable), .newConfig(newConfig)
  );
  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // clear then reprogram every bridge
  task automatic rearm(input logic u);
    host_u.send(1'b1, u, 1'b1, EN, CF);
    host_u.send(1'b0, u, 1'b1, EN, CF);
    w(2);
  endtask
  task automatic t_ocur;
    overcurrentDet = 6'h01;
    w(4);
    chk(latchedOff, 6'h01);
    chk({halfBridgeEnable, halfBridgeConfig}, {6'h3e, CF & 12'hffc});
    chk({overcurrentFlag, faultFrame[BIT_OVERCURRENT]}, 2'h3);
    overcurrentDet = 6'h00;
    w(4);
    chk({latchedOff, overcurrentFlag}, 7'h03);
    host_u.send(1'b0, 1'b0, 1'b1, EN, CF);
    w(1);
    chk({latchedOff, driveAllowed}, {6'h01, 6'h3e});
    host_u.send(1'b1, 1'b0, 1'b1, 6'h3e, CF & 12'hffc);
    w(2);
    chk({latchedOff, overcurrentFlag, halfBridgeEnable}, {7'h00, 6'h3e});
    host_u.send(1'b0, 1'b0, 1'b1, EN, CF);
    w(1);
    chk({driveAllowed, halfBridgeConfig}, {EN, CF});
  endtask
  task automatic t_uload;
    underloadDet = 6'h02;
    w(4);
    chk({underloadFlag, faultFrame[BIT_UNDERLOAD], latchedOff, driveAllowed}, {2'h3, 6'h00, EN});
    underloadDet = 6'h00;
    w(4);
    chk(underloadFlag, 1'b1);
    rearm(1'b1);
    chk(underloadFlag, 1'b0);
    underloadDet = 6'h02;
    w(4);
    chk({latchedOff, halfBridgeEnable}, {6'h02, 6'h3d});
    underloadDet = 6'h00;
    w(3);
    rearm(1'b0);
    chk(latchedOff, 6'h00);
  endtask
  task automatic t_therm;
    thermalWarnDet = 6'h04;
    w(4);
    chk({thermalWarningFlag, faultFrame[BIT_WARN], driveAllowed}, {2'h3, EN});
    thermalWarnDet = 6'h00;
    w(4);
    chk(thermalWarningFlag, 1'b0);
    thermalShutDet = 6'h04;
    w(4);
    chk({latchedOff, thermalShutdownFlag}, 7'h09);
    host_u.send(1'b1, 1'b0, 1'b1, EN, CF);
    w(2);
    chk(latchedOff, 6'h04);
    thermalShutDet = 6'h00;
    w(3);
    rearm(1'b0);
    chk({latchedOff, thermalShutdownFlag}, 7'h00);
  endtask
  task automatic t_supply;
    overvoltageDet = 1'b1;
    w(4);
    chk({driveAllowed, halfBridgeEnable, supplyFailFlag, faultFrame[BIT_SUPPLY_FAIL]}, {6'h00, EN, 2'h3});
    overvoltageDet = 1'b0;
    w(4);
    chk({driveAllowed, supplyFailFlag}, {EN, 1'b0});
    host_u.send(1'b0, 1'b0, 1'b0, EN, CF);
    overvoltageDet = 1'b1;
    w(4);
    chk({driveAllowed, supplyFailFlag}, {EN, 1'b1});
    overvoltageDet = 1'b0;
    undervoltageDet = 1'b1;
    w(4);
    chk({driveAllowed, halfBridgeConfig, supplyFailFlag}, {6'h00, CF, 1'b1});
    undervoltageDet = 1'b0;
    w(4);
    chk({driveAllowed, supplyFailFlag}, {EN, 1'b0});
  endtask
  task automatic t_enpin;
    overcurrentDet = 6'h08;
    w(4);
    overcurrentDet = 6'h00;
    enablePin = 1'b0;
    w(4);
    chk({latchedOff, overcurrentFlag, halfBridgeEnable}, 13'h0000);
    enablePin = 1'b1;
    w(4);
    rearm(1'b0);
    chk(halfBridgeEnable, EN);
  endtask
  // reset, then the scenarios in turn
  initial begin
    {rst, enablePin, overvoltageDet, undervoltageDet} = 4'hc;
    {overcurrentDet, underloadDet, thermalWarnDet, thermalShutDet} = 24'h0;
    w(6);
    rst = 1'b0;
    w(3);
    rearm(1'b0);
    t_ocur();
    t_uload();
    t_therm();
    t_supply();
    t_enpin();
    end_sim();
  end
  // watchdog, far beyond the few microseconds the run needs
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end
endmodule // tb_hbf_fault_mgr
`default_nettype wire
